// [common/adc_cmp_pkg.sv]
// Constants and carrier types for the converter control block.
// Assumes a 32-bit classic Wishbone host; registers sit in bits 7:0 of a word.
package adc_cmp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RES_LO = 8'hC2;
    localparam logic [7:0] IDX_RES_HI = 8'hC3;
    localparam logic [7:0] IDX_CMP_LO = 8'hCE;
    localparam logic [7:0] IDX_CMP_HI = 8'hCF;
    localparam logic [7:0] IDX_CTL2 = 8'hE2;
    localparam logic [7:0] IDX_DLY_LO = 8'hE3;
    localparam logic [7:0] IDX_DIDS = 8'hF6;
    localparam logic [7:0] IDX_CONV = 8'hD0;
    // Fields of compare_brake_control
    localparam int B_BRAKE_EN = 7;
    localparam int B_POL = 6;
    localparam int B_CMP_EN = 5;
    localparam int B_CMP_OUT = 4;
    localparam int B_DLY8 = 0;
    // Fields of the conversion control register
    localparam int B_EXT_SEL = 0;
    localparam int B_BUSY = 1;
    localparam int B_DONE = 2;
    localparam int B_RUN = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_CONV = 2'b10
    } conv_state_e;

    // Answer of the analog core at the end of a conversion
    typedef struct packed {
        logic done;
        logic [11:0] result;
    } conv_rsp_s;
endpackage

// [design/adc_compare_delay_result_regs.sv]
// Converter control: result/compare registers, comparator with fault brake,
// external trigger delay and digital input disconnect.
// Assumes an analog core that answers a start pulse with one done pulse plus result.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module adc_compare_delay_result_regs
    import adc_cmp_pkg::*;
#(
    parameter int RES_W = 12,
    parameter int CH_N = 8,
    parameter int DLY_W = 9
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_trig_i,
    input wire conv_rsp_s conv_rsp_i,
    output logic conv_start_o,
    output logic fault_brake_o,
    output logic pwm_run_o,
    input wire logic [CH_N-1:0] pin_din_i,
    output logic [CH_N-1:0] pin_din_o,
    output logic [CH_N-1:0] din_disable_o
);

    // Field positions are fixed by the register map; other sizes cannot be served
    if (RES_W != 12 || CH_N != 8 || DLY_W != 9) begin : g_size_check
        $error("Register layout serves only 12-bit result, 8 channels, 9-bit delay");
    end

    localparam logic [DLY_W-1:0] DLY_ZERO = '0;
    localparam logic [DLY_W-1:0] DLY_ONE = {{(DLY_W-1){1'b0}}, 1'b1};

    // Comparator decision for a given polarity
    function automatic logic cmp_eval(input logic pol, input logic [11:0] res,
                                      input logic [11:0] thr);
        cmp_eval = pol ? (res < thr) : (res >= thr);
    endfunction

    logic ack_q;
    logic [31:0] rdat_q;
    logic [11:0] result_q;
    logic [11:0] thr_q;
    logic brake_en_q, pol_q, cmp_en_q, cmp_out_q, dly8_q;
    logic [7:0] dly_lo_q;
    logic [7:0] dids_q;
    logic ext_sel_q, done_q, run_q, brake_q, start_q;
    logic [DLY_W-1:0] cnt_q;
    logic [CH_N-1:0] pin_q;
    conv_state_e state_q;

    logic req, wr, rd;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic done_take, trig_take, sw_start, brake_cond;
    logic [DLY_W-1:0] dly_val;
    logic [7:0] rbyte;

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign idx = wb_adr_i[9:2];
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign wbyte = wb_dat_i[7:0];
    assign dly_val = {dly8_q, dly_lo_q};
    assign done_take = (state_q == ST_CONV) && conv_rsp_i.done;
    // triggers count only when idle and no result is waiting
    assign trig_take = (state_q == ST_IDLE) && ext_sel_q && ext_trig_i && !done_q;
    // Software start obeys the same idle and flag checks as a trigger
    assign sw_start = (state_q == ST_IDLE) && !done_q && wr && (idx == IDX_CONV)
                      && wbyte[B_BUSY];
    assign brake_cond = brake_en_q && cmp_out_q;

    always_comb begin
        rbyte = RST_BYTE;
        case (idx)
            IDX_RES_LO: rbyte = {4'h0, result_q[3:0]};
            IDX_RES_HI: rbyte = result_q[11:4];
            IDX_CMP_LO: rbyte = {4'h0, thr_q[3:0]};
            IDX_CMP_HI: rbyte = thr_q[11:4];
            IDX_CTL2: rbyte = {brake_en_q, pol_q, cmp_en_q, cmp_out_q, 3'h0, dly8_q};
            IDX_DLY_LO: rbyte = dly_lo_q;
            IDX_DIDS: rbyte = dids_q;
            IDX_CONV: rbyte = {4'h0, run_q, done_q, state_q != ST_IDLE, ext_sel_q};
            default: rbyte = RST_BYTE;
        endcase
    end

    // Bus answer: one wait state, ack for one enabled cycle; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= RST_WORD;
        end else if (ce_i) begin
            ack_q <= req;
            if (rd) begin
                rdat_q <= {24'h0, rbyte};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_q <= 12'h000;
            dly_lo_q <= RST_BYTE;
            dids_q <= RST_BYTE;
        end else if (ce_i && wr) begin
            if (idx == IDX_CMP_HI) thr_q[11:4] <= wbyte;
            if (idx == IDX_CMP_LO) thr_q[3:0] <= wbyte[3:0];
            if (idx == IDX_DLY_LO) dly_lo_q <= wbyte;
            if (idx == IDX_DIDS) dids_q <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brake_en_q <= 1'b0;
            pol_q <= 1'b0;
            cmp_en_q <= 1'b0;
            dly8_q <= 1'b0;
        end else if (ce_i && wr && idx == IDX_CTL2) begin
            brake_en_q <= wbyte[B_BRAKE_EN];
            pol_q <= wbyte[B_POL];
            cmp_en_q <= wbyte[B_CMP_EN];
            dly8_q <= wbyte[B_DLY8];
        end
    end

    // Comparator output changes only at conversion end or when disabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_out_q <= 1'b0;
        end else if (ce_i) begin
            if (wr && idx == IDX_CTL2 && !wbyte[B_CMP_EN]) begin
                cmp_out_q <= 1'b0;
            end else if (done_take) begin
                cmp_out_q <= cmp_en_q && cmp_eval(pol_q, conv_rsp_i.result, thr_q);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_q <= 12'h000;
        end else if (ce_i && done_take) begin
            result_q <= conv_rsp_i.result;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sel_q <= 1'b0;
        end else if (ce_i && wr && idx == IDX_CONV) begin
            ext_sel_q <= wbyte[B_EXT_SEL];
        end
    end

    // Done flag: software writes zero to clear; a completion in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else if (ce_i) begin
            if (done_take) begin
                done_q <= 1'b1;
            end else if (wr && idx == IDX_CONV && !wbyte[B_DONE]) begin
                done_q <= 1'b0;
            end
        end
    end

    // Run bit: the brake clears it and wins over a software set in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= 1'b0;
            brake_q <= 1'b0;
        end else if (ce_i) begin
            brake_q <= brake_cond;
            if (brake_cond) begin
                run_q <= 1'b0;
            end else if (wr && idx == IDX_CONV) begin
                run_q <= wbyte[B_RUN];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= DLY_ZERO;
            start_q <= 1'b0;
        end else if (ce_i) begin
            start_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (sw_start) begin
                        start_q <= 1'b1;
                        state_q <= ST_CONV;
                    end else if (trig_take) begin
                        cnt_q <= dly_val;
                        state_q <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (cnt_q == DLY_ZERO) begin
                        start_q <= 1'b1;
                        state_q <= ST_CONV;
                    end else begin
                        cnt_q <= cnt_q - DLY_ONE;
                    end
                end
                ST_CONV: begin
                    if (conv_rsp_i.done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Digital reads of a disconnected channel are forced low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= '0;
        end else if (ce_i) begin
            pin_q <= pin_din_i & ~dids_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign conv_start_o = start_q;
    assign fault_brake_o = brake_q;
    assign pwm_run_o = run_q;
    assign pin_din_o = pin_q;
    assign din_disable_o = dids_q;

    // Checks; a frozen clock enable suspends them
    sequence s_trig2;
        trig_take && dly_val == 9'h002;
    endsequence
    sequence s_start_after2;
        !start_q [*3] ##1 start_q;
    endsequence

    chk_brake_assert: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        brake_cond |=> fault_brake_o)
        else $error("Fault brake not asserted");
    chk_run_cleared: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        fault_brake_o |-> !pwm_run_o)
        else $error("Run bit survived a brake");
    chk_cmp_ge: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        done_take && cmp_en_q && !pol_q && !wr |=>
        cmp_out_q == ($past(conv_rsp_i.result) >= thr_q))
        else $error("Greater-or-equal compare wrong");
    chk_cmp_lt: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        done_take && cmp_en_q && pol_q && !wr |=>
        cmp_out_q == ($past(conv_rsp_i.result) < thr_q))
        else $error("Less-than compare wrong");
    chk_cmp_off: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        !cmp_en_q |-> !cmp_out_q ##1 !fault_brake_o)
        else $error("Disabled comparator output set");
    chk_cmp_hold: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        !done_take && !(wr && idx == IDX_CTL2) |=> $stable(cmp_out_q))
        else $error("Comparator output changed without conversion");
    chk_delay_two: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        s_trig2 |=> s_start_after2)
        else $error("Delayed start at wrong cycle");
    chk_delay_zero: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        trig_take && dly_val == DLY_ZERO |=> ##1 conv_start_o)
        else $error("Zero delay start late");
    chk_busy_ignore: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        state_q == ST_CONV && !conv_rsp_i.done |=> !conv_start_o && state_q == ST_CONV)
        else $error("Start issued while busy");
    chk_done_block: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        done_q && state_q == ST_IDLE |=> !conv_start_o)
        else $error("Start while done flag set");
    chk_din_gate: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        1'b1 |=> pin_din_o == ($past(pin_din_i) & ~$past(dids_q)))
        else $error("Disconnected pin read not zero");
    chk_result_take: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        done_take |=> result_q == $past(conv_rsp_i.result))
        else $error("Result not captured");

    // Register path checks
    sequence s_thr_hi_wr;
        wr && idx == IDX_CMP_HI;
    endsequence
    sequence s_thr_lo_wr;
        wr && idx == IDX_CMP_LO;
    endsequence
    chk_thr_high: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        s_thr_hi_wr |=> thr_q[11:4] == $past(wbyte))
        else $error("Compare high byte write lost");
    chk_thr_low: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        s_thr_lo_wr |=> thr_q[3:0] == $past(wbyte[3:0]))
        else $error("Compare low nibble write lost");
    chk_res_high_read: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        rd && idx == IDX_RES_HI |=> wb_dat_o == {24'h0, $past(result_q[11:4])})
        else $error("Result high byte read wrong");
    chk_res_low_read: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        rd && idx == IDX_RES_LO |=> wb_dat_o == {28'h0, $past(result_q[3:0])})
        else $error("Result low nibble read wrong");
    chk_result_hold: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        !done_take |=> $stable(result_q))
        else $error("Result changed without conversion");
    chk_out_read: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        rd && idx == IDX_CTL2 |=> wb_dat_o[B_CMP_OUT] == $past(cmp_out_q))
        else $error("Comparator output read wrong");
    chk_cmp_clear: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wr && idx == IDX_CTL2 && !wbyte[B_CMP_EN] |=> !cmp_out_q)
        else $error("Disable left comparator output set");
    chk_run_resume: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wr && idx == IDX_CONV && wbyte[B_RUN] && !brake_cond |=> pwm_run_o)
        else $error("Run bit not set again");
    chk_done_set: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        done_take |=> done_q)
        else $error("Done flag not set");
    chk_sw_start: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        sw_start |=> conv_start_o && state_q == ST_CONV)
        else $error("Software start not issued");
    chk_busy_read: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        rd && idx == IDX_CONV |=> wb_dat_o[B_BUSY] == ($past(state_q) != ST_IDLE))
        else $error("Busy bit read wrong");
    chk_delay_load: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        trig_take |=> state_q == ST_DELAY && cnt_q == $past(dly_val))
        else $error("Delay count not loaded");
    // Long delays are checked stepwise: one count down per enabled cycle
    chk_delay_count: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        state_q == ST_DELAY && cnt_q != DLY_ZERO |=> cnt_q == $past(cnt_q) - DLY_ONE)
        else $error("Delay counter step wrong");
    chk_dids_write: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wr && idx == IDX_DIDS |=> din_disable_o == $past(wbyte))
        else $error("Disconnect register write lost");
    // An acknowledge must never last two enabled cycles, even under a held strobe; a low enable holds it
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge held too long");
    // These two must see reset and a low enable; the first has no disable, the second is disabled by reset only
    chk_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> !wb_ack_o && !conv_start_o && !fault_brake_o && !pwm_run_o
        && din_disable_o == '0 && thr_q == '0 && result_q == '0 && state_q == ST_IDLE)
        else $error("Register not cleared by reset");
    chk_ce_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(state_q) && $stable(cnt_q) && $stable(run_q) && $stable(wb_ack_o)
        && $stable(pin_din_o) && $stable(thr_q))
        else $error("State moved while clock enable low");
endmodule

// [tb/conv_core_model.sv]
// Behavioural analog core: answers each start pulse with one done pulse.
// Assumes start is a one-cycle pulse from the control block.
`timescale 1ns/1ps
module conv_core_model
    import adc_cmp_pkg::*;
#(
    parameter int LAT = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [11:0] result_i,
    output conv_rsp_s rsp_o
);
    int cnt_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 0;
            rsp_o <= '0;
        end else begin
            rsp_o.done <= 1'b0;
            // Result is only valid with done, so it toggles in between
            rsp_o.result <= ~rsp_o.result;
            if (start_i) begin
                cnt_q <= LAT;
            end else if (cnt_q == 1) begin
                cnt_q <= 0;
                rsp_o <= {1'b1, result_i};
            end else if (cnt_q != 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule

// [tb/tb.sv]
// Self-checking bench for the converter control block.
// Assumes the analog core model and a 100 MHz clock.
`timescale 1ns/1ps
module tb;
    import adc_cmp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [31:0] adr = '0;
    logic [31:0] dat = '0;
    logic [31:0] rdat;
    logic ack;
    logic ext_trig = 1'b0;
    logic ce = 1'b1;
    logic [7:0] pin_in = '0;
    logic [11:0] res_v = '0;
    conv_rsp_s rsp;
    logic start, brake, run;
    logic [7:0] pin_out, dis;
    logic run_v = 1'b0;
    logic ext_v = 1'b0;
    logic [31:0] r;
    int miscompares = 0;
    int num_checks = 0;
    int starts = 0;

    adc_compare_delay_result_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trig_i(ext_trig),
        .conv_rsp_i(rsp), .conv_start_o(start), .fault_brake_o(brake), .pwm_run_o(run),
        .pin_din_i(pin_in), .pin_din_o(pin_out), .din_disable_o(dis));
    conv_core_model #(.LAT(4)) core (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
        .result_i(res_v), .rsp_o(rsp));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (start === 1'b1) begin
            starts++;
        end
    end

    task automatic tally_and_finish();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(inout int n);
        @(posedge clk_i);
        n++;
        if (n > 60) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {22'h0, idx, 2'b00};
        dat <= {24'h0, d};
        do begin
            tick(n);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(r, exp);
    endtask
    task automatic convert(input logic [11:0] v);
        int n;
        n = 0;
        res_v <= v;
        wr(IDX_CONV, {4'h0, run_v, 2'b00, ext_v});
        wr(IDX_CONV, {4'h0, run_v, 2'b01, ext_v});
        while (rsp.done !== 1'b1) begin
            tick(n);
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset();
        logic [7:0] idx [8] = '{IDX_RES_LO, IDX_RES_HI, IDX_CMP_LO, IDX_CMP_HI,
            IDX_CTL2, IDX_DLY_LO, IDX_DIDS, 8'h10};
        chk({start, brake, run, dis}, 32'h0);
        foreach (idx[i]) begin
            rd(idx[i], 32'h0);
        end
        $display("test reset done");
    endtask
    task automatic t_cmp();
        wr(IDX_CMP_HI, 8'hAB);
        wr(IDX_CMP_LO, 8'hFC);
        rd(IDX_CMP_HI, 32'hAB);
        rd(IDX_CMP_LO, 32'h0C);
        wr(IDX_CTL2, 8'h20);
        convert(12'hABC);
        rd(IDX_RES_HI, 32'hAB);
        rd(IDX_RES_LO, 32'h0C);
        rd(IDX_CTL2, 32'h30);
        wr(IDX_RES_HI, 8'h00);
        rd(IDX_RES_HI, 32'hAB);
        convert(12'hABB);
        rd(IDX_CTL2, 32'h20);
        wr(IDX_CTL2, 8'h60);
        convert(12'hABB);
        rd(IDX_CTL2, 32'h70);
        convert(12'hABC);
        rd(IDX_CTL2, 32'h60);
        wr(IDX_CTL2, 8'h50);
        convert(12'h000);
        rd(IDX_CTL2, 32'h40);
        $display("test compare done");
    endtask
    task automatic t_brake();
        run_v = 1'b1;
        wr(IDX_CTL2, 8'h80);
        convert(12'hFFF);
        chk({brake, run}, 32'h1);
        wr(IDX_CTL2, 8'hA0);
        convert(12'hFFF);
        chk({brake, run}, 32'h2);
        run_v = 1'b0;
        rd(IDX_CONV, 32'h04);
        wr(IDX_CTL2, 8'h20);
        run_v = 1'b1;
        wr(IDX_CONV, {4'h0, run_v, 3'b100});
        @(posedge clk_i);
        chk({brake, run}, 32'h1);
        $display("test brake done");
    endtask
    task automatic t_done();
        int s0;
        s0 = starts;
        wr(IDX_CONV, {4'h0, run_v, 3'b110});
        repeat (5) @(posedge clk_i);
        chk(starts - s0, 32'h0);
        $display("test done flag done");
    endtask
    task automatic t_ext();
        int first;
        int s0;
        first = -1;
        wr(IDX_DLY_LO, 8'h05);
        wr(IDX_CTL2, 8'h01);
        rd(IDX_CTL2, 32'h01);
        ext_v = 1'b1;
        wr(IDX_CONV, {4'h0, run_v, 2'b00, ext_v});
        s0 = starts;
        @(posedge clk_i);
        ext_trig <= 1'b1;
        @(posedge clk_i);
        ext_trig <= 1'b0;
        for (int k = 1; k < 300; k++) begin
            @(posedge clk_i);
            // Second trigger lands inside the delay phase
            ext_trig <= (k == 5);
            #1;
            if (start === 1'b1 && first < 0) begin
                first = k;
            end
        end
        chk(first, 32'd262);
        chk(starts - s0, 32'h1);
        $display("test trigger delay done");
    endtask
    task automatic t_dids();
        wr(IDX_DIDS, 8'hF0);
        @(posedge clk_i);
        pin_in <= 8'hFF;
        repeat (3) @(posedge clk_i);
        chk({dis, pin_out}, 32'hF00F);
        pin_in <= 8'h5A;
        repeat (3) @(posedge clk_i);
        chk(pin_out, 32'h0A);
        rd(IDX_DIDS, 32'hF0);
        $display("test disconnect done");
    endtask
    task automatic t_trig(input logic [8:0] d);
        int n;
        n = 0;
        wr(IDX_DLY_LO, d[7:0]);
        wr(IDX_CTL2, {7'h00, d[8]});
        wr(IDX_CONV, {4'h0, run_v, 2'b00, ext_v});
        ext_trig <= 1'b1;
        @(posedge clk_i);
        ext_trig <= 1'b0;
        while (start !== 1'b1) begin
            tick(n);
        end
        chk(n, {23'h0, d} + 32'd2);
        repeat (8) @(posedge clk_i);
        $display("test short delay done");
    endtask
    task automatic t_ce();
        @(posedge clk_i);
        ce <= 1'b0;
        pin_in <= 8'h0F;
        repeat (3) @(posedge clk_i);
        chk(pin_out, 32'h0A);
        ce <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(pin_out, 32'h0F);
        $display("test clock enable done");
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_cmp();
        t_brake();
        t_done();
        t_ext();
        t_trig(9'h000);
        t_trig(9'h002);
        t_dids();
        t_ce();
        tally_and_finish();
    end
endmodule
